// file: dv/host_model.sv
// host side model: card clock, decoded commands, reset pin
`timescale 1ns/1ps
module host_model (
    input  wire         REF_CLK,
    output logic        LINK_CLK,
    output logic        CMD_LINE,
    output logic        CMD_VALID,
    output logic [5:0]  CMD_INDEX,
    output logic [31:0] CMD_ARG,
    output logic        HW_RESET_N
);
    logic run = 1'b0;
    int   link_edges = 0;
    initial begin
        LINK_CLK = 1'b0;
        CMD_LINE = 1'b1;
        CMD_VALID = 1'b0;
        CMD_INDEX = 6'h00;
        CMD_ARG = 32'h0000_0000;
        HW_RESET_N = 1'b1;
        // odd offset keeps card edges away from the reference edges
        #3;
        forever begin
            #80;
            if (run || LINK_CLK) LINK_CLK = ~LINK_CLK;
        end
    end
    always @(posedge LINK_CLK) link_edges++;
    task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
        int first_edge;
        first_edge = link_edges;
        run = 1'b1;
        // fresh clocks before every command, so a power cycle is covered too
        while (link_edges - first_edge < 74) @(posedge REF_CLK);
        run = 1'b0;
        @(posedge REF_CLK);
        CMD_VALID <= 1'b1;
        CMD_INDEX <= idx;
        CMD_ARG <= arg;
        @(posedge REF_CLK);
        CMD_VALID <= 1'b0;
        CMD_INDEX <= ~idx;
        CMD_ARG <= ~arg;
    endtask
    task automatic cmd_level(input logic v);
        CMD_LINE <= v;
        run = !v;
    endtask
    task automatic rst_pin(input logic v, input int ns);
        HW_RESET_N <= v;
        #(ns);
    endtask
    task automatic hw_reset;
        rst_pin(1'b0, 1100);
        rst_pin(1'b1, 5);
        rst_pin(1'b0, 1100);
        rst_pin(1'b1, 200_000);
    endtask
endmodule // host_model

// file: dv/mode_ctrl_properties.sv
// port assertions for the mode controller
`timescale 1ns/1ps
`include "mode_ctrl_consts.vh"
module mode_ctrl_properties (
    input wire        REF_CLK,
    input wire        RSTN,
    input wire        HW_RESET_N,
    input wire        CMD_VALID,
    input wire [5:0]  CMD_INDEX,
    input wire [31:0] CMD_ARG,
    input wire        READ_ACTIVE,
    input wire        CRC_STATUS_ACTIVE,
    input wire [7:0]  DAT_OE,
    input wire        STROBE,
    input wire        CMD_PUSH_PULL,
    input wire        BOOT_ACTIVE,
    input wire        INTERNAL_RESET
);
    logic [7:0] high_cnt;
    logic [7:0] low_cnt;
    logic       armed;
    // raw pin run lengths, saturating so long levels never wrap
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            high_cnt <= 8'h00;
            low_cnt  <= 8'h00;
            armed    <= 1'b0;
        end else begin
            high_cnt <= !HW_RESET_N ? 8'h00 : high_cnt + {7'h00, high_cnt != 8'hFF};
            low_cnt  <= HW_RESET_N ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
            // a low of 1 us owes a reset; a short high glitch after it owes none
            if (INTERNAL_RESET)
                armed <= 1'b0;
            else if (low_cnt == 8'h64)
                armed <= 1'b1;
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    property p_rst_pulse; INTERNAL_RESET |=> !INTERNAL_RESET; endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset pulse too long");
    property p_rst_filter; INTERNAL_RESET |-> high_cnt >= 8'h32; endproperty
    a_rst_filter: assert property (p_rst_filter)
        else $error("reset from short pulse");
    property p_rst_detect; high_cnt == 8'h64 |-> !armed; endproperty
    a_rst_detect: assert property (p_rst_detect)
        else $error("long reset pulse missed");
    property p_strobe_idle; (!READ_ACTIVE && !CRC_STATUS_ACTIVE) [*4] |-> $stable(STROBE); endproperty
    a_strobe_idle: assert property (p_strobe_idle)
        else $error("strobe moved while idle");
    property p_lane0; INTERNAL_RESET |-> ##2 DAT_OE[7:1] == 7'h00; endproperty
    a_lane0: assert property (p_lane0)
        else $error("wide lanes after reset");
    property p_ident; CMD_VALID && CMD_INDEX == `CMD_SEND_OP |-> ##3 DAT_OE == 8'h00; endproperty
    a_ident: assert property (p_ident)
        else $error("data driven in identification");
    property p_boot;
        CMD_VALID && CMD_INDEX == `CMD_GO_IDLE && CMD_ARG == `BOOT_ARG |-> ##[1:3] BOOT_ACTIVE;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot request ignored");
    property p_inact;
        CMD_VALID && CMD_INDEX == `CMD_INACTIVE |-> ##[1:3] !CMD_PUSH_PULL && !BOOT_ACTIVE;
    endproperty
    a_inact: assert property (p_inact)
        else $error("inactive command ignored");
    c_boot: cover property ($rose(BOOT_ACTIVE));
    c_strobe: cover property ($rose(STROBE));
    c_reset: cover property (INTERNAL_RESET);
endmodule // mode_ctrl_properties
bind mode_ctrl mode_ctrl_properties chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .HW_RESET_N(HW_RESET_N), .CMD_VALID(CMD_VALID), .CMD_INDEX(CMD_INDEX), .CMD_ARG(CMD_ARG),
    .READ_ACTIVE(READ_ACTIVE), .CRC_STATUS_ACTIVE(CRC_STATUS_ACTIVE), .DAT_OE(DAT_OE),
    .STROBE(STROBE), .CMD_PUSH_PULL(CMD_PUSH_PULL), .BOOT_ACTIVE(BOOT_ACTIVE),
    .INTERNAL_RESET(INTERNAL_RESET));

// file: dv/test_emmc_mode_reset_fwupdate.sv
// self-checking bench for the mode controller
`timescale 1ns/1ps
`include "mode_ctrl_consts.vh"
module test_emmc_mode_reset_fwupdate;
    logic        REF_CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [3:0]  ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0000_0000;
    logic        RANGE_BAD = 1'b0, POWER_CYCLE = 1'b0, SECTOR_DONE = 1'b0, SECTOR_OK = 1'b0;
    logic        READ_ACTIVE = 1'b0, CRC_STATUS_ACTIVE = 1'b0;
    logic [7:0]  TX_DATA_RISE = 8'hA5, TX_DATA_FALL = 8'h5A, speed_now = 8'h00;
    wire  [31:0] RDATA, CMD_ARG;
    wire  [7:0]  DAT_OUT, DAT_OE;
    wire  [5:0]  CMD_INDEX;
    wire         LINK_CLK, CMD_LINE, CMD_VALID, HW_RESET_N, STROBE, CMD_PUSH_PULL;
    wire         BOOT_ACTIVE, BOOT_FROM_USER, INTERNAL_RESET, FW_DOWNLOAD_MODE;
    int          failures = 0, samples_checked = 0, resets_seen = 0;
    logic [31:0] rd_val;
    // {accepted, 0, width, 0, speed}
    logic [7:0]  rows [12] = '{8'h30, 8'h25, 8'h80, 8'hA0, 8'h01, 8'h91, 8'hA2, 8'h93, 8'h03,
                               8'h14, 8'hA4, 8'h04};
    always #5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) if (INTERNAL_RESET === 1'b1) resets_seen++;
    mode_ctrl dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .LINK_CLK(LINK_CLK), .HW_RESET_N(HW_RESET_N),
        .CMD_LINE(CMD_LINE), .CMD_VALID(CMD_VALID), .CMD_INDEX(CMD_INDEX), .CMD_ARG(CMD_ARG),
        .RANGE_BAD(RANGE_BAD), .POWER_CYCLE(POWER_CYCLE), .READ_ACTIVE(READ_ACTIVE),
        .CRC_STATUS_ACTIVE(CRC_STATUS_ACTIVE), .SECTOR_DONE(SECTOR_DONE), .SECTOR_OK(SECTOR_OK),
        .TX_DATA_RISE(TX_DATA_RISE), .TX_DATA_FALL(TX_DATA_FALL), .DAT_OUT(DAT_OUT),
        .DAT_OE(DAT_OE), .STROBE(STROBE), .CMD_PUSH_PULL(CMD_PUSH_PULL),
        .BOOT_ACTIVE(BOOT_ACTIVE), .BOOT_FROM_USER(BOOT_FROM_USER),
        .INTERNAL_RESET(INTERNAL_RESET), .FW_DOWNLOAD_MODE(FW_DOWNLOAD_MODE));
    host_model host (.REF_CLK(REF_CLK), .LINK_CLK(LINK_CLK), .CMD_LINE(CMD_LINE),
        .CMD_VALID(CMD_VALID), .CMD_INDEX(CMD_INDEX), .CMD_ARG(CMD_ARG), .HW_RESET_N(HW_RESET_N));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 rd_val = RDATA;
        @(posedge REF_CLK);
        chk(rd_val, exp, what);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    task automatic pulse(input int kind);
        if (kind == 0) POWER_CYCLE <= 1'b1;
        else SECTOR_DONE <= 1'b1;
        SECTOR_OK <= kind == 1;
        @(posedge REF_CLK);
        POWER_CYCLE <= 1'b0;
        SECTOR_DONE <= 1'b0;
        cycles(3);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(900_000);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        cycles(12);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        rd_chk(`REG_FWCFG, 32'h0000_0004, "fwcfg");
        rd_chk(`REG_SECTORS, 32'h0000_0000, "sectors");
        rd_chk(4'hF, 32'h0000_0000, "unmapped");
        host.send_cmd(`CMD_GO_IDLE, `BOOT_ARG);
        cycles(4);
        chk(DAT_OE, 8'h01, "boot lanes");
        rd_chk(`REG_OPMODE, {29'h0, `OP_BOOT}, "boot");
        wr_reg(`REG_FWCFG, 32'h0000_0006);
        cycles(1);
        chk(BOOT_FROM_USER, 1'b1, "user area");
        wr_reg(`REG_FWCFG, 32'h0000_0004);
        cycles(1);
        chk(BOOT_FROM_USER, 1'b0, "boot area");
        foreach (rows[i]) begin
            wr_reg(`REG_SPEED, {24'h0, rows[i] & 8'h37});
            if (rows[i][7]) speed_now = rows[i] & 8'h37;
            rd_chk(`REG_SPEED, {24'h0, speed_now}, "speed");
            rd_chk(`REG_STATUS, {28'h0, !rows[i][7], 3'h3}, "refusal");
            wr_reg(`REG_EVENT, 32'h0000_0001);
        end
        host.send_cmd(`CMD_SEND_OP, 32'h0000_0000);
        rd_chk(`REG_OPMODE, {29'h0, `OP_IDENT}, "ident");
        chk(CMD_PUSH_PULL, 1'b0, "open drain");
        host.send_cmd(6'h03, 32'h0000_0000);
        cycles(3);
        chk(CMD_PUSH_PULL, 1'b1, "push pull");
        host.send_cmd(6'h07, 32'h0000_0000);
        rd_chk(`REG_OPMODE, {29'h0, `OP_TRANSFER}, "transfer");
        host.run = 1'b1;
        READ_ACTIVE <= 1'b1;
        for (int k = 0; k < 200 && STROBE !== 1'b1; k++) @(posedge REF_CLK);
        #1 chk(DAT_OUT, TX_DATA_RISE, "rise data");
        chk(DAT_OE, 8'hFF, "eight lanes");
        for (int k = 0; k < 200 && STROBE !== 1'b0; k++) @(posedge REF_CLK);
        #1 chk(DAT_OUT, TX_DATA_FALL, "fall data");
        @(posedge REF_CLK);
        READ_ACTIVE <= 1'b0;
        CRC_STATUS_ACTIVE <= 1'b1;
        cycles(40);
        CRC_STATUS_ACTIVE <= 1'b0;
        host.run = 1'b0;
        cycles(40);
        chk(STROBE, 1'b0, "strobe idle");
        wr_reg(`REG_FWCFG, 32'h0000_0005);
        chk(FW_DOWNLOAD_MODE, 1'b1, "fw mode");
        pulse(1);
        pulse(2);
        pulse(1);
        wr_reg(`REG_FWCFG, 32'h0000_0004);
        chk(FW_DOWNLOAD_MODE, 1'b0, "fw exit");
        rd_chk(`REG_SECTORS, 32'h0000_0002, "kept count");
        wr_reg(`REG_FWCFG, 32'h0000_000C);
        rd_chk(`REG_SECTORS, 32'h0000_0000, "count clear");
        host.send_cmd(`CMD_INACTIVE, 32'h0000_0000);
        host.send_cmd(`CMD_SEND_OP, 32'h0000_0000);
        rd_chk(`REG_OPMODE, {29'h0, `OP_INACTIVE}, "stay inactive");
        pulse(0);
        host.send_cmd(`CMD_SEND_OP, 32'h0000_0000);
        RANGE_BAD <= 1'b1;
        cycles(3);
        rd_chk(`REG_OPMODE, {29'h0, `OP_INACTIVE}, "bad range");
        RANGE_BAD <= 1'b0;
        pulse(0);
        rd_chk(`REG_OPMODE, {29'h0, `OP_PREIDLE}, "power cycle");
        host.cmd_level(1'b0);
        for (int k = 0; k < 3000 && BOOT_ACTIVE !== 1'b1; k++) @(posedge REF_CLK);
        rd_chk(`REG_OPMODE, {29'h0, `OP_BOOT}, "line boot");
        cycles(20);
        chk(DAT_OUT, 8'h01, "boot data");
        host.cmd_level(1'b1);
        wr_reg(`REG_SPEED, 32'h0000_0022);
        wr_reg(`REG_FWCFG, 32'h0000_0005);
        resets_seen = 0;
        host.rst_pin(1'b0, 5);
        host.rst_pin(1'b1, 2003);
        host.rst_pin(1'b0, 303);
        host.rst_pin(1'b1, 2003);
        host.hw_reset();
        @(posedge REF_CLK);
        chk(resets_seen, 1, "reset count");
        rd_chk(`REG_OPMODE, {29'h0, `OP_PREIDLE}, "pin reset");
        rd_chk(`REG_SPEED, 32'h0000_0000, "speed reset");
        chk(FW_DOWNLOAD_MODE, 1'b0, "fw abort");
        stop_test();
    end
endmodule // test_emmc_mode_reset_fwupdate

// file: logic/mode_ctrl.v
// device-side bus speed, operating mode, hardware reset filter and firmware download control
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mode_ctrl_consts.vh"
// Function
// - legacy, high-speed and 200 MHz speed modes
// - 200 MHz single rate: one bit per clock
// - 200 MHz double rate requires 8-bit bus
// - strobe toggles only for read data, CRC
// - read data aligned to strobe edges
// - device only answers host commands
// - boot on CMD low or boot argument
// - boot data from boot or user area
// - identification uses command line only
// - push-pull from stand-by onward
// - inactive on bad range or CMD15; power-cycle exit
// - reset sequence on reset rising edge
// - ignore reset pulses of 5 ns or less
// - detect reset pulses of 1 us or more
// - firmware mode entered through mode field
// - keep sector count for resume after exit
// - reset before completion may abort download
// - 200 MHz double rate: two bits per strobe cycle
// - only data line zero after reset
module mode_ctrl (
    input  wire        REF_CLK,
    input  wire        RSTN,
    input  wire [3:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    input  wire        LINK_CLK,
    input  wire        HW_RESET_N,
    input  wire        CMD_LINE,
    input  wire        CMD_VALID,
    input  wire [5:0]  CMD_INDEX,
    input  wire [31:0] CMD_ARG,
    input  wire        RANGE_BAD,
    input  wire        POWER_CYCLE,
    input  wire        READ_ACTIVE,
    input  wire        CRC_STATUS_ACTIVE,
    input  wire        SECTOR_DONE,
    input  wire        SECTOR_OK,
    input  wire [7:0]  TX_DATA_RISE,
    input  wire [7:0]  TX_DATA_FALL,
    output reg  [7:0]  DAT_OUT,
    output reg  [7:0]  DAT_OE,
    output reg         STROBE,
    output reg         CMD_PUSH_PULL,
    output reg         BOOT_ACTIVE,
    output reg         BOOT_FROM_USER,
    output reg         INTERNAL_RESET,
    output reg         FW_DOWNLOAD_MODE
);

    reg [2:0]  speed_mode;
    reg [1:0]  bus_width;
    reg        boot_user_sel;
    reg        fw_supported;
    reg [2:0]  op_mode;
    reg [31:0] programmed_sector_count;
    reg [15:0] relative_bus_address;
    reg [1:0]  rst_sync;
    reg [1:0]  clk_sync;
    reg [1:0]  cmd_sync;
    reg        rst_filt;
    reg        rst_filt_d;
    reg [8:0]  stable_cnt;
    reg        clk_prev;
    reg [6:0]  clk_count;
    reg        cfg_error;
    reg [2:0]  next_op;

    wire clk_rise = clk_sync[1] & ~clk_prev;
    wire clk_fall = ~clk_sync[1] & clk_prev;
    wire rst_rise = rst_filt & ~rst_filt_d;
    wire is_ddr200 = (speed_mode == `SPD_DDR200);
    wire in_data = (op_mode == `OP_STANDBY) || (op_mode == `OP_TRANSFER);
    wire strobe_on = is_ddr200 && in_data && (READ_ACTIVE || CRC_STATUS_ACTIVE);

    // lane mask for the configured width; wider lanes stay released
    function [7:0] lane_mask;
        input [1:0] w;
        begin
            case (w)
                `BW_4:   lane_mask = 8'h0F;
                `BW_8:   lane_mask = 8'hFF;
                default: lane_mask = 8'h01;
            endcase
        end
    endfunction

    // legacy allows any width, high-speed needs 4/8, double-rate 200 MHz needs 8
    function width_ok;
        input [2:0] s;
        input [1:0] w;
        begin
            case (s)
                `SPD_LEGACY: width_ok = (w != 2'h3);
                `SPD_DDR200: width_ok = (w == `BW_8);
                `SPD_HS_SDR, `SPD_HS_DDR, `SPD_SDR200:
                    width_ok = (w == `BW_4) || (w == `BW_8);
                default:     width_ok = 1'b0;
            endcase
        end
    endfunction

    // pin synchronisers
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync <= 2'h3;
            clk_sync <= 2'h0;
            cmd_sync <= 2'h3;
        end else begin
            rst_sync <= {rst_sync[0], HW_RESET_N};
            clk_sync <= {clk_sync[0], LINK_CLK};
            cmd_sync <= {cmd_sync[0], CMD_LINE};
        end
    end

    // a level change is accepted only after staying put well past 5 ns and before 1 us
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_filt   <= 1'b1;
            rst_filt_d <= 1'b1;
            stable_cnt <= 9'h000;
            clk_prev   <= 1'b0;
        end else begin
            rst_filt_d <= rst_filt;
            clk_prev   <= clk_sync[1];
            if (rst_sync[1] == rst_filt) begin
                stable_cnt <= 9'h000;
            end else if (stable_cnt == (`RST_STABLE_CYC - 1)) begin
                rst_filt   <= rst_sync[1];
                stable_cnt <= 9'h000;
            end else begin
                stable_cnt <= stable_cnt + 9'h001;
            end
        end
    end

    // operating mode sequencing
    always @* begin
        next_op = op_mode;
        case (op_mode)
            `OP_PREIDLE, `OP_BOOT: begin
                if (clk_count == `PREBOOT_CLKS && !cmd_sync[1] && op_mode == `OP_PREIDLE)
                    next_op = `OP_BOOT;
                else if (CMD_VALID && CMD_INDEX == `CMD_GO_IDLE && CMD_ARG == `BOOT_ARG)
                    next_op = `OP_BOOT;
                else if (CMD_VALID && CMD_INDEX == `CMD_SEND_OP)
                    next_op = `OP_IDENT;
                else if (op_mode == `OP_BOOT && cmd_sync[1] && !CMD_VALID
                         && clk_count == `PREBOOT_CLKS)
                    next_op = `OP_BOOT;
            end
            `OP_IDENT: begin
                if (RANGE_BAD)
                    next_op = `OP_INACTIVE;
                else if (CMD_VALID && CMD_INDEX == 6'h03)
                    next_op = `OP_STANDBY;
            end
            `OP_STANDBY, `OP_TRANSFER: begin
                if (CMD_VALID && CMD_INDEX == 6'h07)
                    next_op = (op_mode == `OP_STANDBY) ? `OP_TRANSFER : `OP_STANDBY;
            end
            `OP_INACTIVE: next_op = `OP_INACTIVE;
            default:      next_op = `OP_PREIDLE;
        endcase
        if (op_mode != `OP_INACTIVE && CMD_VALID && CMD_INDEX == `CMD_INACTIVE)
            next_op = `OP_INACTIVE;
        if (op_mode != `OP_INACTIVE && op_mode != `OP_PREIDLE && CMD_VALID
            && CMD_INDEX == `CMD_GO_IDLE && CMD_ARG != `BOOT_ARG)
            next_op = `OP_PREIDLE;
        if (POWER_CYCLE)
            next_op = `OP_PREIDLE;
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            op_mode        <= `OP_PREIDLE;
            clk_count      <= 7'h00;
            INTERNAL_RESET <= 1'b0;
        end else begin
            INTERNAL_RESET <= rst_rise;
            if (rst_rise) begin
                op_mode   <= `OP_PREIDLE;
                clk_count <= 7'h00;
            end else begin
                op_mode <= next_op;
                if (op_mode != next_op)
                    clk_count <= 7'h00;
                else if (clk_rise && clk_count != `PREBOOT_CLKS)
                    clk_count <= clk_count + 7'h01;
            end
        end
    end

    // configuration, firmware download and register writes
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            speed_mode              <= `SPD_LEGACY;
            bus_width               <= `BW_1;
            boot_user_sel           <= 1'b0;
            fw_supported            <= 1'b1;
            FW_DOWNLOAD_MODE        <= 1'b0;
            programmed_sector_count <= 32'h0000_0000;
            relative_bus_address    <= `ADDR_RESET;
            cfg_error               <= 1'b0;
        end else begin
            if (rst_rise || POWER_CYCLE) begin
                speed_mode       <= `SPD_LEGACY;
                bus_width        <= `BW_1;
                FW_DOWNLOAD_MODE <= 1'b0;
            end else if (WR) begin
                case (ADDR)
                    `REG_SPEED: begin
                        if (width_ok(WDATA[2:0], WDATA[5:4])) begin
                            speed_mode <= WDATA[2:0];
                            bus_width  <= WDATA[5:4];
                        end else begin
                            cfg_error <= 1'b1;
                        end
                    end
                    `REG_FWCFG: begin
                        boot_user_sel <= WDATA[1];
                        fw_supported  <= WDATA[2];
                        if (WDATA[0] && fw_supported)
                            FW_DOWNLOAD_MODE <= 1'b1;
                        else if (!WDATA[0])
                            FW_DOWNLOAD_MODE <= 1'b0;
                        if (WDATA[3])
                            programmed_sector_count <= 32'h0000_0000;
                    end
                    `REG_ADDR:  relative_bus_address <= WDATA[15:0];
                    `REG_EVENT: if (WDATA[0]) cfg_error <= 1'b0;
                    default: ;
                endcase
            end
            // counted sectors survive leaving the mode so the host can resume
            if (FW_DOWNLOAD_MODE && SECTOR_DONE && SECTOR_OK && !rst_rise)
                programmed_sector_count <= programmed_sector_count + 32'h0000_0001;
        end
    end

    // data lines, strobe and driver mode
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DAT_OUT       <= 8'h00;
            DAT_OE        <= 8'h00;
            STROBE        <= 1'b0;
            CMD_PUSH_PULL <= 1'b0;
            BOOT_ACTIVE   <= 1'b0;
            BOOT_FROM_USER <= 1'b0;
        end else begin
            CMD_PUSH_PULL  <= in_data;
            BOOT_ACTIVE    <= (op_mode == `OP_BOOT);
            BOOT_FROM_USER <= boot_user_sel;
            if (op_mode == `OP_IDENT || op_mode == `OP_PREIDLE || op_mode == `OP_INACTIVE) begin
                DAT_OE <= 8'h00;
                STROBE <= 1'b0;
            end else if (READ_ACTIVE || CRC_STATUS_ACTIVE || op_mode == `OP_BOOT) begin
                DAT_OE <= lane_mask(bus_width);
                if (is_ddr200 && in_data) begin
                    // data changes with each strobe edge, two bits per line a cycle
                    if (clk_rise) begin
                        DAT_OUT <= TX_DATA_RISE & lane_mask(bus_width);
                        STROBE  <= strobe_on;
                    end else if (clk_fall) begin
                        DAT_OUT <= TX_DATA_FALL & lane_mask(bus_width);
                        STROBE  <= 1'b0;
                    end
                end else if (clk_fall) begin
                    DAT_OUT <= TX_DATA_RISE & lane_mask(bus_width);
                    STROBE  <= 1'b0;
                end
            end else begin
                DAT_OE <= 8'h00;
                STROBE <= 1'b0;
            end
        end
    end

    // register reads, data one cycle after the strobe
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `REG_SPEED:   RDATA <= {26'h0, bus_width, 1'b0, speed_mode};
                `REG_OPMODE:  RDATA <= {29'h0, op_mode};
                `REG_STATUS:  RDATA <= {28'h0, cfg_error, FW_DOWNLOAD_MODE,
                                        BOOT_ACTIVE, rst_filt};
                `REG_FWCFG:   RDATA <= {29'h0, fw_supported, boot_user_sel, FW_DOWNLOAD_MODE};
                `REG_SECTORS: RDATA <= programmed_sector_count;
                `REG_ADDR:    RDATA <= {16'h0, relative_bus_address};
                default:      RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

endmodule // mode_ctrl

// file: logic/mode_ctrl_consts.vh
// constants for the device-side mode, reset and firmware-download controller
`ifndef MODE_CTRL_CONSTS_VH
`define MODE_CTRL_CONSTS_VH
// register offsets (plain port, 4-bit address)
`define REG_SPEED        4'h0
`define REG_OPMODE       4'h1
`define REG_STATUS       4'h2
`define REG_FWCFG        4'h3
`define REG_SECTORS      4'h4
`define REG_ADDR         4'h5
`define REG_EVENT        4'h6
// speed mode encodings
`define SPD_LEGACY       3'h0
`define SPD_HS_SDR       3'h1
`define SPD_HS_DDR       3'h2
`define SPD_SDR200       3'h3
`define SPD_DDR200       3'h4
// bus width encodings
`define BW_1             2'h0
`define BW_4             2'h1
`define BW_8             2'h2
// operating modes
`define OP_PREIDLE       3'h0
`define OP_BOOT          3'h1
`define OP_IDENT         3'h2
`define OP_STANDBY       3'h3
`define OP_TRANSFER      3'h4
`define OP_INACTIVE      3'h5
// boot request argument and command indices (inactive, go-idle, send-op)
`define BOOT_ARG         32'hFFFF_FFFA
`define CMD_INACTIVE     6'h0F
`define CMD_GO_IDLE      6'h00
`define CMD_SEND_OP      6'h01
// reset filter timing, ns
`define CLK_PERIOD_NS    10
`define GLITCH_MAX_NS    5
`define RST_MIN_NS       1000
// filter accepts a level once stable for this many cycles (under 1 us, above 5 ns)
`define RST_STABLE_CYC   ((`RST_MIN_NS / `CLK_PERIOD_NS) / 2)
`define PREBOOT_CLKS     7'h4A
`define ADDR_RESET       16'h0001
`endif
